// ==== dsic_pkg.sv ====
// How it works
// RULE_01: transmit data taken from the TXD input
// RULE_02: received bits driven out on RXD
// RULE_03: effective RTS is pin OR software bit
// RULE_04: send TXD data only after CTS active
// RULE_05: half-duplex RTS starts training before data
// RULE_06: CTS active only when ready to send
// RULE_07: RLSD needs energy above threshold, not training
// RULE_08: four thresholds, two dB hysteresis, programmable
// RULE_09: effective DTR is pin OR software bit
// RULE_10: high-speed DTR starts handshake when data bit set
// RULE_11: answer mode sends answer tone at once; code sends none in half duplex mode
// RULE_12: low-speed DTR enters data; carrier follows RTS
// RULE_13: DTR drop in data mode returns idle
// RULE_14: DSR on in data state, off in loopback
// RULE_15: terminal ignores circuits but RI while DSR off
// RULE_16: status bit mirrors the DSR output
// RULE_17: RI low while ringing; status bit mirrors it
// RULE_18: transmit bit clock at data rate, symmetric
// RULE_19: transmit clock internal, external or receive-slaved
// RULE_20: external clock reproduced on transmit clock output
// RULE_21: receive bit clock at data rate, symmetric
// RULE_22: receive clock rises at centre of bit
// RULE_23: RTS to CTS delay from programmable table
// RULE_24: terminal changes TXD on falling, device samples rising
package dsic_pkg;
    localparam int CLK_MHZ = 40;
    localparam int RATE_W = 16;
    localparam int DLY_W = 16;
    localparam int LVL_W = 8;
    localparam int TBL_DEPTH = 4;
    localparam int TBL_AW = 2;
    // delay table reset value, per mode
    localparam int CTS_DELAY_US = 10;
    localparam logic [DLY_W-1:0] CTS_DELAY_CYC = DLY_W'(CTS_DELAY_US * CLK_MHZ);
    // levels are attenuation in dB below 0 dBm: larger means weaker
    localparam logic [LVL_W-1:0] HYST_DB = 8'h02;
    localparam logic [LVL_W-1:0] THR_ON_0 = 8'h2B;
    localparam logic [LVL_W-1:0] THR_ON_1 = 8'h21;
    localparam logic [LVL_W-1:0] THR_ON_2 = 8'h1A;
    localparam logic [1:0] THR_SEL_PROG = 2'h3;

    typedef enum logic [1:0] {
        DSIC_MODE_HALF = 2'b00,
        DSIC_MODE_HSFD = 2'b01,
        DSIC_MODE_LSFD = 2'b10
    } dsic_mode_t;

    typedef enum logic [1:0] {
        DSIC_CLK_INT = 2'b00,
        DSIC_CLK_EXT = 2'b01,
        DSIC_CLK_SLAVE = 2'b10
    } dsic_clksrc_t;

    typedef enum logic [1:0] {
        DSIC_ST_IDLE = 2'b00,
        DSIC_ST_HANDSHAKE = 2'b01,
        DSIC_ST_DATA = 2'b10
    } dsic_phase_t;

    typedef struct packed {
        logic sw_rts;
        logic sw_dtr;
        logic data_mode;
        logic answer_mode;
        logic ctrl_carrier;
        logic test_loop;
        dsic_mode_t mode;
        dsic_clksrc_t clk_src;
        logic [1:0] detect_threshold_select;
        logic [LVL_W-1:0] prog_on_db;
        logic [LVL_W-1:0] prog_off_db;
    } dsic_ctrl_t;

    typedef struct packed {
        logic demod_bit;
        logic demod_valid;
        logic [LVL_W-1:0] energy_db;
        logic training;
        logic ring_on;
        logic handshake_done;
    } dsic_rx_t;

    typedef struct packed {
        logic tx_bit;
        logic tx_valid;
        logic training;
        logic answer_tone;
        logic handshake;
        logic tx_on;
        logic rx_on;
        logic carrier_on;
    } dsic_pump_t;

    typedef struct packed {
        logic [1:0] txd_s;
        logic [1:0] rts_s;
        logic [1:0] dtr_s;
        logic [1:0] xclk_s;
        dsic_phase_t phase;
        logic [DLY_W-1:0] dly_cnt;
        logic cts_n;
        logic rlsd_n;
        logic dsr_n;
        logic ri_n;
        logic dsr_stat;
        logic ri_stat;
        logic rxd;
        logic rx_clk;
        logic [RATE_W-1:0] rx_cnt;
        logic tx_int;
        logic [RATE_W-1:0] tx_cnt;
        logic transmit_bit_clock_out;
        dsic_pump_t pump;
    } dsic_state_t;

    localparam dsic_state_t DSIC_STATE_RST = '{
        txd_s: 2'h3, rts_s: 2'h3, dtr_s: 2'h3, xclk_s: 2'h0,
        phase: DSIC_ST_IDLE, dly_cnt: '0,
        cts_n: 1'b1, rlsd_n: 1'b1, dsr_n: 1'b1, ri_n: 1'b1,
        dsr_stat: 1'b0, ri_stat: 1'b0, rxd: 1'b1, rx_clk: 1'b1,
        rx_cnt: '0, tx_int: 1'b0, tx_cnt: '0, transmit_bit_clock_out: 1'b0, pump: '0
    };
endpackage

// ==== dsic_delay_table.sv ====
`timescale 1ns/10ps
module dsic_delay_table #(
    parameter int W = 16,
    parameter int DEPTH = 4,
    parameter int AW = 2,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem_reg [DEPTH];

    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad
        $error("delay table depth does not fit its address");
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= INIT;
            end
            rdata <= INIT;
        end else begin
            if (we && (32'(waddr) < DEPTH)) begin
                mem_reg[waddr] <= wdata;
            end
            rdata <= (32'(raddr) < DEPTH) ? mem_reg[raddr] : INIT;
        end
    end
endmodule

// ==== dsic_top.sv ====
`timescale 1ns/10ps
module dsic_top (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic TXD,
    input wire logic RTS_N,
    input wire logic DTR_N,
    input wire logic EXTERNAL_TRANSMIT_CLOCK_IN,
    input wire dsic_pkg::dsic_ctrl_t CTRL,
    input wire dsic_pkg::dsic_rx_t RX,
    input wire logic [dsic_pkg::RATE_W-1:0] BIT_HALF_CYCLES,
    input wire logic TBL_WE,
    input wire logic [dsic_pkg::TBL_AW-1:0] TBL_ADDR,
    input wire logic [dsic_pkg::DLY_W-1:0] TBL_WDATA,
    output logic RXD,
    output logic CTS_N,
    output logic RLSD_N,
    output logic DSR_N,
    output logic RI_N,
    output logic TRANSMIT_BIT_CLOCK_OUT,
    output logic RECEIVE_BIT_CLOCK_OUT,
    output logic DSR_STATUS,
    output logic RI_STATUS,
    output dsic_pkg::dsic_pump_t PUMP
);
    import dsic_pkg::*;

    dsic_state_t s_reg;
    dsic_state_t s_next;
    logic [DLY_W-1:0] cts_delay;
    logic rts;
    logic dtr;
    logic [LVL_W-1:0] on_db;
    logic [LVL_W-1:0] off_db;

    if (TBL_DEPTH < 3 || RATE_W < 2) begin : g_bad
        $error("delay table or rate counter too small");
    end

    // active-low pin and software bit, either one asserts
    function automatic logic asserted(input logic pin_n, input logic sw);
        return !pin_n || sw;
    endfunction

    function automatic logic [LVL_W-1:0] on_level(input logic [1:0] sel, input logic [LVL_W-1:0] prog);
        case (sel)
            2'h0: return THR_ON_0;
            2'h1: return THR_ON_1;
            2'h2: return THR_ON_2;
            default: return prog;
        endcase
    endfunction

    dsic_delay_table #(
        .W(DLY_W),
        .DEPTH(TBL_DEPTH),
        .AW(TBL_AW),
        .INIT(CTS_DELAY_CYC)
    ) u_table (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .we(TBL_WE),
        .waddr(TBL_ADDR),
        .wdata(TBL_WDATA),
        .raddr(CTRL.mode),
        .rdata(cts_delay)
    );

    assign rts = asserted(s_reg.rts_s[1], CTRL.sw_rts); // RULE_03
    assign dtr = asserted(s_reg.dtr_s[1], CTRL.sw_dtr); // RULE_09
    assign on_db = on_level(CTRL.detect_threshold_select, CTRL.prog_on_db); // RULE_08

    // off level never closer than the hysteresis to the on level, except when clipped at FF
    always_comb begin
        logic [LVL_W:0] min_off;
        min_off = {1'b0, on_db} + {1'b0, HYST_DB};
        off_db = min_off[LVL_W] ? {LVL_W{1'b1}} : min_off[LVL_W-1:0];
        if (CTRL.detect_threshold_select == THR_SEL_PROG && CTRL.prog_off_db > off_db) begin
            off_db = CTRL.prog_off_db; // RULE_08
        end
    end

    always_comb begin
        logic tx_src;
        tx_src = 1'b0;
        s_next = s_reg;
        // pin synchronisers: stage 1 read only by stage 2
        s_next.txd_s = {s_reg.txd_s[0], TXD};
        s_next.rts_s = {s_reg.rts_s[0], RTS_N};
        s_next.dtr_s = {s_reg.dtr_s[0], DTR_N};
        s_next.xclk_s = {s_reg.xclk_s[0], EXTERNAL_TRANSMIT_CLOCK_IN};

        case (s_reg.phase)
            DSIC_ST_IDLE: begin
                if (dtr && CTRL.data_mode) begin
                    case (CTRL.mode)
                        DSIC_MODE_HSFD: s_next.phase = DSIC_ST_HANDSHAKE; // RULE_10
                        DSIC_MODE_LSFD: s_next.phase = DSIC_ST_DATA; // RULE_12
                        DSIC_MODE_HALF: s_next.phase = DSIC_ST_DATA;
                        default: s_next.phase = DSIC_ST_IDLE;
                    endcase
                end
            end
            DSIC_ST_HANDSHAKE: begin
                if (!dtr) begin
                    s_next.phase = DSIC_ST_IDLE;
                end else if (RX.handshake_done) begin
                    s_next.phase = DSIC_ST_DATA;
                end
            end
            DSIC_ST_DATA: begin
                if (!dtr) begin
                    s_next.phase = DSIC_ST_IDLE; // RULE_13
                end
            end
            default: s_next.phase = DSIC_ST_IDLE;
        endcase

        // rts to cts: count the mode's table delay, train meanwhile in half duplex
        if (s_next.phase == DSIC_ST_DATA && rts) begin
            if (s_reg.cts_n) begin
                if (s_reg.dly_cnt >= cts_delay) begin
                    s_next.cts_n = 1'b0; // RULE_04 RULE_06 RULE_23
                    s_next.pump.training = 1'b0;
                end else begin
                    s_next.dly_cnt = s_reg.dly_cnt + 1'b1;
                    s_next.pump.training = (CTRL.mode == DSIC_MODE_HALF); // RULE_05
                end
            end
        end else begin
            s_next.cts_n = 1'b1;
            s_next.dly_cnt = '0;
            s_next.pump.training = 1'b0;
        end

        s_next.pump.handshake = (s_next.phase == DSIC_ST_HANDSHAKE);
        s_next.pump.answer_tone = CTRL.answer_mode && ((s_next.phase == DSIC_ST_HANDSHAKE) ||
            (s_next.phase == DSIC_ST_DATA && CTRL.mode == DSIC_MODE_LSFD)); // RULE_11
        s_next.pump.tx_on = (s_next.phase != DSIC_ST_IDLE); // RULE_13
        s_next.pump.rx_on = (s_next.phase != DSIC_ST_IDLE);
        if (s_next.phase != DSIC_ST_DATA) begin
            s_next.pump.carrier_on = 1'b0;
        end else if (CTRL.mode == DSIC_MODE_LSFD && CTRL.ctrl_carrier) begin
            s_next.pump.carrier_on = rts; // RULE_12
        end else if (CTRL.mode == DSIC_MODE_HALF) begin
            s_next.pump.carrier_on = s_next.pump.training || !s_next.cts_n;
        end else begin
            s_next.pump.carrier_on = 1'b1;
        end

        s_next.dsr_n = !(s_next.phase == DSIC_ST_DATA && !CTRL.test_loop); // RULE_14
        s_next.dsr_stat = !s_next.dsr_n; // RULE_16
        s_next.ri_n = !RX.ring_on; // RULE_17
        s_next.ri_stat = RX.ring_on;

        // detector: on at or stronger than on level, off once weaker than off level
        if (RX.training) begin
            s_next.rlsd_n = 1'b1; // RULE_07
        end else if (RX.energy_db <= on_db) begin
            s_next.rlsd_n = 1'b0; // RULE_07
        end else if (RX.energy_db > off_db) begin
            s_next.rlsd_n = 1'b1;
        end

        // receive clock low in the first half of each bit, rising mid-bit
        if (RX.demod_valid) begin
            s_next.rxd = RX.demod_bit; // RULE_02
            s_next.rx_clk = 1'b0; // RULE_22
            s_next.rx_cnt = '0;
        end else if (!s_reg.rx_clk) begin
            if (s_reg.rx_cnt + 1'b1 >= BIT_HALF_CYCLES) begin
                s_next.rx_clk = 1'b1; // RULE_21 RULE_22
            end else begin
                s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
            end
        end

        // internal clock: symmetric, one toggle per half bit
        if (s_reg.tx_cnt + 1'b1 >= BIT_HALF_CYCLES) begin
            s_next.tx_cnt = '0;
            s_next.tx_int = !s_reg.tx_int; // RULE_18
        end else begin
            s_next.tx_cnt = s_reg.tx_cnt + 1'b1;
        end

        case (CTRL.clk_src)
            DSIC_CLK_EXT: tx_src = s_reg.xclk_s[1]; // RULE_19 RULE_20
            DSIC_CLK_SLAVE: tx_src = s_reg.rx_clk; // RULE_19
            default: tx_src = s_reg.tx_int; // RULE_19
        endcase
        s_next.transmit_bit_clock_out = tx_src;

        // sample on the rising edge; terminal moves data on the falling one
        s_next.pump.tx_valid = tx_src && !s_reg.transmit_bit_clock_out && !s_reg.cts_n; // RULE_24 RULE_04
        if (tx_src && !s_reg.transmit_bit_clock_out) begin
            s_next.pump.tx_bit = s_reg.txd_s[1]; // RULE_01
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_reg <= DSIC_STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign RXD = s_reg.rxd;
    assign CTS_N = s_reg.cts_n;
    assign RLSD_N = s_reg.rlsd_n;
    assign DSR_N = s_reg.dsr_n;
    assign RI_N = s_reg.ri_n;
    assign TRANSMIT_BIT_CLOCK_OUT = s_reg.transmit_bit_clock_out;
    assign RECEIVE_BIT_CLOCK_OUT = s_reg.rx_clk;
    assign DSR_STATUS = s_reg.dsr_stat;
    assign RI_STATUS = s_reg.ri_stat;
    assign PUMP = s_reg.pump;

    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    sequence hs_request;
        s_reg.phase == DSIC_ST_IDLE && dtr && CTRL.data_mode && CTRL.mode == DSIC_MODE_HSFD;
    endsequence

    sequence ls_request;
        s_reg.phase == DSIC_ST_IDLE && dtr && CTRL.data_mode && CTRL.mode == DSIC_MODE_LSFD;
    endsequence

    a_hs_start: assert property (hs_request |=> s_reg.phase == DSIC_ST_HANDSHAKE) // RULE_10
        else $error("handshake not started on dtr");
    a_ls_data: assert property (ls_request |=> s_reg.phase == DSIC_ST_DATA ##0 !s_reg.pump.handshake) // RULE_12
        else $error("low speed mode did not enter data state");
    a_dtr_drop: assert property (s_reg.phase == DSIC_ST_DATA && !dtr |=> s_reg.phase == DSIC_ST_IDLE
        ##1 !s_reg.pump.tx_on && !s_reg.pump.rx_on) // RULE_13
        else $error("dtr drop did not return to idle");
    // cts lags rts by one edge, so the drop of rts is judged a cycle late
    a_cts_ready: assert property (!s_reg.cts_n |-> s_reg.phase == DSIC_ST_DATA && $past(rts)) // RULE_06
        else $error("cts active outside data state or without rts");
    a_tx_gated: assert property (s_reg.pump.tx_valid |-> $past(!s_reg.cts_n)
        && s_reg.pump.tx_bit == $past(s_reg.txd_s[1], 1)) // RULE_04
        else $error("transmit sample without cts");
    a_train_first: assert property ($fell(s_reg.cts_n) && CTRL.mode == DSIC_MODE_HALF
        && $stable(CTRL.mode) |-> $past(s_reg.pump.training)) // RULE_05
        else $error("half duplex cts without training");
    a_dsr_state: assert property (!s_reg.dsr_n |-> s_reg.phase == DSIC_ST_DATA
        && s_reg.dsr_stat && $past(!CTRL.test_loop)) // RULE_14 RULE_16
        else $error("dsr on outside data state or in loopback");
    a_ri_follow: assert property (RX.ring_on |=> !s_reg.ri_n && s_reg.ri_stat) // RULE_17
        else $error("ring indicator does not follow ringing");
    a_rlsd_train: assert property (RX.training |=> s_reg.rlsd_n) // RULE_07
        else $error("carrier detect active during training");
    a_rx_centre: assert property (RX.demod_valid |=> !s_reg.rx_clk && s_reg.rxd == $past(RX.demod_bit)) // RULE_22
        else $error("receive clock not low at bit start");
    a_slave_clk: assert property (CTRL.clk_src == DSIC_CLK_SLAVE |=> s_reg.transmit_bit_clock_out == $past(s_reg.rx_clk)) // RULE_19
        else $error("slaved transmit clock does not track receive clock");
    a_ext_clk: assert property (CTRL.clk_src == DSIC_CLK_EXT [*3] |-> s_reg.transmit_bit_clock_out == $past(EXTERNAL_TRANSMIT_CLOCK_IN, 3)) // RULE_20
        else $error("external clock not reproduced");
endmodule

// ==== dsic_term_model.sv ====
`timescale 1ns/10ps
module dsic_term_model (
    input wire logic tclk,
    input wire logic dsr_n,
    input wire logic cts_n,
    input wire logic go,
    input wire logic ext_en,
    input wire logic [7:0] pattern,
    output logic txd,
    output logic ext_clk,
    output logic done
);
    int idx;
    initial begin
        txd = 1'b1;
        ext_clk = 1'b0;
        done = 1'b0;
        idx = 0;
    end
    // offset keeps edges clear of the system clock; parked low when off
    initial begin
        #7;
        forever #100 ext_clk = ext_en ? ~ext_clk : 1'b0;
    end
    always @(negedge tclk) begin
        if (!go) begin
            idx <= 0;
            done <= 1'b0;
            txd <= 1'b1;
        end else if (!dsr_n && !cts_n && !done) begin
            txd <= (idx < 8) ? pattern[3'(7 - idx)] : 1'b1;
            done <= (idx == 8);
            idx <= idx + 1;
        end
    end
endmodule

// ==== dsic_top_tb.sv ====
`timescale 1ns/10ps
module dsic_top_tb;
    import dsic_pkg::*;
    localparam int H = 4;
    localparam int D = 6;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic rts_n = 1'b1;
    logic dtr_n = 1'b1;
    logic tbl_we = 1'b0;
    logic [TBL_AW-1:0] tbl_addr = '0;
    logic [DLY_W-1:0] tbl_wdata = '0;
    logic [RATE_W-1:0] half = RATE_W'(H);
    dsic_ctrl_t ctrl = '0;
    dsic_rx_t rx = '{energy_db: 8'hFF, default: '0};
    logic txd, ext_clk, done, prev_rclk, v;
    logic go = 1'b0;
    logic ext_en = 1'b0;
    logic slave_chk = 1'b0;
    logic rxd, cts_n, rlsd_n, dsr_n, ri_n, tclk, rclk, dsr_st, ri_st;
    dsic_pump_t pump;
    logic [7:0] sreg = 8'h00;
    logic [7:0] on_lvl [4] = '{8'h2B, 8'h21, 8'h1A, 8'h30};
    logic [7:0] off_lvl [4] = '{8'h2D, 8'h23, 8'h1C, 8'h38};
    logic [3:0] pat = 4'h9;
    int num_errors = 0;
    int total_checks = 0;

    always #12.5 clk = ~clk;

    dsic_top dut (.CLK(clk), .ARST_N(arst_n), .TXD(txd), .RTS_N(rts_n), .DTR_N(dtr_n),
        .EXTERNAL_TRANSMIT_CLOCK_IN(ext_clk), .CTRL(ctrl), .RX(rx), .BIT_HALF_CYCLES(half),
        .TBL_WE(tbl_we), .TBL_ADDR(tbl_addr), .TBL_WDATA(tbl_wdata), .RXD(rxd), .CTS_N(cts_n),
        .RLSD_N(rlsd_n), .DSR_N(dsr_n), .RI_N(ri_n), .TRANSMIT_BIT_CLOCK_OUT(tclk),
        .RECEIVE_BIT_CLOCK_OUT(rclk), .DSR_STATUS(dsr_st), .RI_STATUS(ri_st), .PUMP(pump));
    dsic_term_model term (.tclk(tclk), .dsr_n(dsr_n), .cts_n(cts_n), .go(go), .ext_en(ext_en),
        .pattern(8'hB4), .txd(txd), .ext_clk(ext_clk), .done(done));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string name);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic det(input logic [7:0] e, input logic tr, input logic exp);
        rx.energy_db = e;
        rx.training = tr;
        tick(2);
        chk(rlsd_n, exp, "rlsd");
    endtask

    always @(posedge clk) prev_rclk <= rclk;
    always @(negedge clk) begin
        if (pump.tx_valid)
            sreg <= {sreg[6:0], pump.tx_bit};
        if (slave_chk)
            chk(tclk, prev_rclk, "slave tclk");
    end

    initial begin
        #200000;
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        tick(1);
        chk({cts_n, rlsd_n, dsr_n, ri_n, rxd, rclk, dsr_st, ri_st, tclk}, 9'h1F8, "reset");
        chk(pump, 8'h00, "reset pump");
        $display("reset test done");
        ctrl.prog_on_db = 8'h30;
        ctrl.prog_off_db = 8'h38;
        for (int s = 0; s < 4; s++) begin
            ctrl.detect_threshold_select = 2'(s);
            det(on_lvl[s], 1'b0, 1'b0);
            det(off_lvl[s], 1'b0, 1'b0);
            det(on_lvl[s], 1'b1, 1'b1);
            det(off_lvl[s] + 8'h01, 1'b0, 1'b1);
            det(off_lvl[s], 1'b0, 1'b1);
        end
        $display("detector test done");
        rx.ring_on = 1'b1;
        tick(2);
        chk({ri_n, ri_st}, 2'b01, "ring on");
        rx.ring_on = 1'b0;
        tick(2);
        chk({ri_n, ri_st}, 2'b10, "ring off");
        $display("ring test done");
        // data bit clear: pin must be ignored
        ctrl.mode = DSIC_MODE_HSFD;
        ctrl.answer_mode = 1'b1;
        dtr_n = 1'b0;
        tick(5);
        chk(pump.handshake, 1'b0, "refused");
        dtr_n = 1'b1;
        tick(4);
        ctrl.data_mode = 1'b1;
        dtr_n = 1'b0;
        tick(5);
        chk({pump.handshake, pump.answer_tone, pump.tx_on, dsr_n}, 4'hF, "handshake");
        rx.handshake_done = 1'b1;
        tick(2);
        rx.handshake_done = 1'b0;
        chk({dsr_n, dsr_st}, 2'b01, "data");
        tbl_addr = 2'(DSIC_MODE_HSFD);
        tbl_wdata = DLY_W'(D);
        tbl_we = 1'b1;
        tick(0);
        tbl_we = 1'b0;
        tick(2);
        ctrl.sw_rts = 1'b1;
        tick(D);
        chk(cts_n, 1'b1, "cts early");
        tick(1);
        chk(cts_n, 1'b0, "cts");
        go = 1'b1;
        for (int i = 0; i < 400 && !done; i++)
            tick(0);
        if (!done) begin
            num_errors++;
            complete_run();
        end
        chk(sreg, 8'hB4, "tx bits");
        go = 1'b0;
        ctrl.sw_rts = 1'b0;
        tick(2);
        chk(cts_n, 1'b1, "cts drop");
        rts_n = 1'b0;
        tick(D + 5);
        chk(cts_n, 1'b0, "pin rts");
        rts_n = 1'b1;
        ctrl.sw_dtr = 1'b1;
        dtr_n = 1'b1;
        tick(4);
        chk(dsr_n, 1'b0, "sw dtr");
        ctrl.sw_dtr = 1'b0;
        tick(2);
        chk({dsr_n, pump.tx_on, pump.rx_on}, 3'b100, "dtr drop");
        $display("handshake and transmit test done");
        ctrl.mode = DSIC_MODE_HALF;
        ctrl.sw_dtr = 1'b1;
        tick(2);
        chk(dsr_n, 1'b0, "half data");
        ctrl.sw_rts = 1'b1;
        tick(int'(CTS_DELAY_CYC));
        chk({cts_n, pump.training}, 2'b11, "training");
        tick(1);
        chk({cts_n, pump.training}, 2'b00, "half cts");
        ctrl.sw_rts = 1'b0;
        ctrl.sw_dtr = 1'b0;
        tick(2);
        ctrl.mode = DSIC_MODE_LSFD;
        ctrl.ctrl_carrier = 1'b1;
        ctrl.sw_dtr = 1'b1;
        tick(2);
        chk({dsr_n, pump.answer_tone, pump.carrier_on}, 3'b010, "low speed");
        ctrl.sw_rts = 1'b1;
        tick(2);
        chk(pump.carrier_on, 1'b1, "carrier");
        ctrl.sw_rts = 1'b0;
        ctrl.sw_dtr = 1'b0;
        ctrl.test_loop = 1'b1;
        tick(2);
        ctrl.sw_dtr = 1'b1;
        tick(2);
        chk(dsr_n, 1'b1, "loopback");
        ctrl.sw_dtr = 1'b0;
        ctrl.test_loop = 1'b0;
        $display("half and low speed test done");
        ctrl.clk_src = DSIC_CLK_SLAVE;
        tick(1);
        slave_chk = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rx.demod_bit = pat[i];
            rx.demod_valid = 1'b1;
            tick(0);
            rx.demod_valid = 1'b0;
            tick(0);
            chk({rxd, rclk}, {pat[i], 1'b0}, "rx bit");
            tick(H - 2);
            chk(rclk, 1'b0, "rx clk low");
            tick(1);
            chk(rclk, 1'b1, "rx clk mid");
            tick(H - 1);
        end
        slave_chk = 1'b0;
        ctrl.clk_src = DSIC_CLK_EXT;
        ext_en = 1'b1;
        for (int i = 0; i < 8; i++) begin
            v = ext_clk;
            for (int k = 0; k < 300 && ext_clk === v; k++)
                #1;
            if (ext_clk === v) begin
                num_errors++;
                complete_run();
            end
            v = ext_clk;
            #90;
            chk(tclk, v, "ext clk");
        end
        ext_en = 1'b0;
        $display("clock test done");
        complete_run();
    end
endmodule
